// *** src/rtc_map.svh ***
// Constants for the seconds counter and millisecond wake timer.
// Assumes the oscillator clock on clock_i; included by bare name.
`ifndef RTC_MAP_SVH
`define RTC_MAP_SVH
`define RTC_CLK_HZ 20000000
`define RTC_SEC_HZ 1
`define RTC_MS_HZ 1000
`define RTC_MS_DIV (`RTC_CLK_HZ / `RTC_MS_HZ)
`define RTC_SEC_DIV (`RTC_MS_HZ / `RTC_SEC_HZ)
`define RTC_SEC_RST 32'h0000_0000
`define RTC_MATCH_RST 32'hffff_ffff
`define RTC_MS_RST 16'h0000
`endif

// *** src/rtc_pkg.sv ***
// Types for the seconds counter and millisecond wake timer.
// Assumes nothing beyond a SystemVerilog compiler.
package rtc_pkg;
  typedef struct packed {
    logic clear;
    logic load;
    logic [31:0] value;
  } rtc_sec_wr_t;
  typedef enum logic {RTC_MS_IDLE, RTC_MS_RUN} rtc_ms_state_t;
endpackage : rtc_pkg

// *** src/rtc_timers.sv ***
// Seconds up-counter with alarm match, and millisecond down-counting wake timer.
// Assumes software strobes come from logic on clock_i (no synchroniser needed).
`include "rtc_map.svh"

////////////////////////////////////////////////////////////////////////////////
// How it works
// - Divide the oscillator clock into a 1 kHz tick, then a 1 Hz tick.
// - Seconds counter is 32 bits; software may clear it or load a start value.
// - While enabled, seconds counter increments on every 1 Hz tick that has no coincident clear or load.
// - Alarm interrupt pulses when the seconds count becomes equal to the match value.
// - Alarm also raises a wake request for low-power modes.
// - Fine timer is 16-bit down counter, decrements on 1 kHz tick only when enabled.
// - Writing a non-zero count loads it and starts the countdown at once.
// - At zero the fine timer disables itself and pulses its interrupt in the same cycle; wake follows a cycle later.
// - Alarm and fine timer drive two separate interrupt outputs.
// - Fine timer expiry also raises a wake request.
module rtc_timers
  import rtc_pkg::*;
#(
  parameter int MS_DIV = `RTC_MS_DIV,
  parameter int SEC_DIV = `RTC_SEC_DIV
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // Seconds counter control
  input wire logic sec_enable_i,
  input wire rtc_sec_wr_t sec_wr_i,
  input wire logic match_wr_i,
  input wire logic [31:0] match_value_i,
  // Fine timer control
  input wire logic ms_wr_i,
  input wire logic [15:0] ms_value_i,
  // State
  output logic [31:0] sec_count_o,
  output logic [15:0] ms_count_o,
  output logic ms_running_o,
  // Requests
  output logic alarm_irq_o,
  output logic ms_irq_o,
  output logic wake_o
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [31:0] div_ms;
  logic [31:0] div_sec;
  logic tick_ms;
  logic tick_sec;
  logic [31:0] match;
  logic [31:0] next_sec;
  logic [31:0] next_match;
  rtc_ms_state_t ms_state;

  ////////////////////////////////////////////////////////////////////////////////
  // Tick generation; the 1 Hz tick trails a 1 kHz tick by one cycle
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_ms <= 32'h0;
      tick_ms <= 1'b0;
    end else if (div_ms == 32'(MS_DIV - 1)) begin
      div_ms <= 32'h0;
      tick_ms <= 1'b1;
    end else begin
      div_ms <= div_ms + 32'h1;
      tick_ms <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_sec <= 32'h0;
      tick_sec <= 1'b0;
    end else begin
      tick_sec <= 1'b0;
      if (tick_ms) begin
        if (div_sec == 32'(SEC_DIV - 1)) begin
          div_sec <= 32'h0;
          tick_sec <= 1'b1;
        end else begin
          div_sec <= div_sec + 32'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Seconds counter; software writes win over a coincident tick
  always_comb begin
    next_sec = sec_count_o;
    if (sec_wr_i.clear) begin
      next_sec = `RTC_SEC_RST;
    end else if (sec_wr_i.load) begin
      next_sec = sec_wr_i.value;
    end else if (sec_enable_i && tick_sec) begin
      next_sec = sec_count_o + 32'h1;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sec_count_o <= `RTC_SEC_RST;
    end else begin
      sec_count_o <= next_sec;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      match <= `RTC_MATCH_RST;
    end else if (match_wr_i) begin
      match <= match_value_i;
    end
  end

  // Match as it stands after this edge, so a coincident rewrite is honoured
  always_comb begin
    next_match = match_wr_i ? match_value_i : match;
  end

  // Fires only on the change into equality, so a parked count does not re-fire
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      alarm_irq_o <= 1'b0;
    end else begin
      alarm_irq_o <= (next_sec == next_match) && (next_sec != sec_count_o);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Fine timer
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ms_state <= RTC_MS_IDLE;
      ms_count_o <= `RTC_MS_RST;
      ms_irq_o <= 1'b0;
    end else begin
      ms_irq_o <= 1'b0;
      if (ms_wr_i) begin
        // A rewrite while running relaunches; zero stops silently
        ms_count_o <= ms_value_i;
        ms_state <= (ms_value_i != 16'h0) ? RTC_MS_RUN : RTC_MS_IDLE;
      end else begin
        unique case (ms_state)
          RTC_MS_IDLE: begin
          end
          RTC_MS_RUN: begin
            if (tick_ms) begin
              ms_count_o <= ms_count_o - 16'h1;
              if (ms_count_o == 16'h1) begin
                ms_state <= RTC_MS_IDLE;
                ms_irq_o <= 1'b1;
              end
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ms_running_o <= 1'b0;
    end else begin
      ms_running_o <= (ms_state == RTC_MS_RUN);
    end
  end

  // Wake is a pulse one cycle after either interrupt
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wake_o <= 1'b0;
    end else begin
      wake_o <= alarm_irq_o || ms_irq_o;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_alarm_eq;
    @(posedge clock_i) disable iff (!rst_b_i)
      alarm_irq_o |-> (sec_count_o == match);
  endproperty
  a_alarm_eq: assert property (p_alarm_eq) else $error("alarm without match");

  property p_sec_inc;
    @(posedge clock_i) disable iff (!rst_b_i)
      (tick_sec && sec_enable_i && !sec_wr_i.clear && !sec_wr_i.load)
        |=> (sec_count_o == $past(sec_count_o) + 32'h1);
  endproperty
  a_sec_inc: assert property (p_sec_inc) else $error("seconds did not step");

  property p_sec_hold;
    @(posedge clock_i) disable iff (!rst_b_i)
      (!tick_sec && !sec_wr_i.clear && !sec_wr_i.load) |=> $stable(sec_count_o);
  endproperty
  a_sec_hold: assert property (p_sec_hold) else $error("seconds moved off tick");

  property p_sec_clear;
    @(posedge clock_i) disable iff (!rst_b_i)
      sec_wr_i.clear |=> (sec_count_o == 32'h0);
  endproperty
  a_sec_clear: assert property (p_sec_clear) else $error("clear failed");

  property p_sec_tick_on_ms;
    @(posedge clock_i) disable iff (!rst_b_i)
      tick_sec |-> $past(tick_ms);
  endproperty
  a_sec_tick_on_ms: assert property (p_sec_tick_on_ms) else $error("tick misaligned");

  property p_ms_start;
    @(posedge clock_i) disable iff (!rst_b_i)
      (ms_wr_i && ms_value_i != 16'h0) |=> (ms_state == RTC_MS_RUN) ##1 ms_running_o;
  endproperty
  a_ms_start: assert property (p_ms_start) else $error("fine timer not started");

  property p_ms_zero;
    @(posedge clock_i) disable iff (!rst_b_i)
      (ms_wr_i && ms_value_i == 16'h0) |=> (ms_state == RTC_MS_IDLE) && !ms_irq_o;
  endproperty
  a_ms_zero: assert property (p_ms_zero) else $error("zero write started timer");

  property p_ms_expire;
    @(posedge clock_i) disable iff (!rst_b_i)
      ms_irq_o |-> (ms_count_o == 16'h0) && (ms_state == RTC_MS_IDLE) ##1 wake_o;
  endproperty
  a_ms_expire: assert property (p_ms_expire) else $error("bad expiry");

  property p_ms_dec;
    @(posedge clock_i) disable iff (!rst_b_i)
      (ms_state == RTC_MS_RUN && tick_ms && !ms_wr_i)
        |=> (ms_count_o == $past(ms_count_o) - 16'h1);
  endproperty
  a_ms_dec: assert property (p_ms_dec) else $error("fine timer did not step");

  property p_ms_idle_hold;
    @(posedge clock_i) disable iff (!rst_b_i)
      (ms_state == RTC_MS_IDLE && !ms_wr_i) |=> $stable(ms_count_o) && !ms_irq_o;
  endproperty
  a_ms_idle_hold: assert property (p_ms_idle_hold) else $error("idle timer moved");

  property p_wake_cause;
    @(posedge clock_i) disable iff (!rst_b_i)
      wake_o |-> $past(alarm_irq_o) || $past(ms_irq_o);
  endproperty
  a_wake_cause: assert property (p_wake_cause) else $error("wake without cause");

  property p_sec_off;
    @(posedge clock_i) disable iff (!rst_b_i)
      (!sec_enable_i && !sec_wr_i.clear && !sec_wr_i.load) |=> $stable(sec_count_o);
  endproperty
  a_sec_off: assert property (p_sec_off) else $error("disabled seconds moved");

  property p_match_load;
    @(posedge clock_i) disable iff (!rst_b_i)
      match_wr_i |=> (match == $past(match_value_i));
  endproperty
  a_match_load: assert property (p_match_load) else $error("match not loaded");

  property p_alarm_wake;
    @(posedge clock_i) disable iff (!rst_b_i)
      alarm_irq_o |=> wake_o;
  endproperty
  a_alarm_wake: assert property (p_alarm_wake) else $error("alarm did not wake");

  property p_tick_ms_phase;
    @(posedge clock_i) disable iff (!rst_b_i)
      tick_ms |-> (div_ms == 32'h0);
  endproperty
  a_tick_ms_phase: assert property (p_tick_ms_phase) else $error("tick off phase");

  property p_ms_load;
    @(posedge clock_i) disable iff (!rst_b_i)
      ms_wr_i |=> (ms_count_o == $past(ms_value_i));
  endproperty
  a_ms_load: assert property (p_ms_load) else $error("fine timer not loaded");

  property p_ms_running_lag;
    @(posedge clock_i) disable iff (!rst_b_i)
      ms_running_o |-> ($past(ms_state) == RTC_MS_RUN);
  endproperty
  a_ms_running_lag: assert property (p_ms_running_lag) else $error("running flag wrong");

  property p_ms_run_hold;
    @(posedge clock_i) disable iff (!rst_b_i)
      (ms_state == RTC_MS_RUN && !tick_ms && !ms_wr_i) |=> $stable(ms_count_o);
  endproperty
  a_ms_run_hold: assert property (p_ms_run_hold) else $error("count moved off tick");

  property p_ms_irq_pulse;
    @(posedge clock_i) disable iff (!rst_b_i)
      ms_irq_o |=> !ms_irq_o;
  endproperty
  a_ms_irq_pulse: assert property (p_ms_irq_pulse) else $error("expiry not a pulse");

  c_alarm: cover property (@(posedge clock_i) disable iff (!rst_b_i) alarm_irq_o);
  c_ms_exp: cover property (@(posedge clock_i) disable iff (!rst_b_i) ms_irq_o);
  c_relaunch: cover property (@(posedge clock_i) disable iff (!rst_b_i)
    ms_running_o && ms_wr_i);
  c_both: cover property (@(posedge clock_i) disable iff (!rst_b_i) alarm_irq_o && ms_irq_o);
  c_zero_write: cover property (@(posedge clock_i) disable iff (!rst_b_i)
    ms_wr_i && (ms_value_i == 16'h0));

endmodule : rtc_timers

// *** verification/rtc_power_model.sv ***
// Far-side power logic: counts each interrupt line, sleeps and wakes.
// Assumes request pulses are registered on clock_i.
module rtc_power_model (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // Requests
  input wire logic sleep_req_i,
  input wire logic alarm_irq_i,
  input wire logic ms_irq_i,
  input wire logic wake_i,
  // Observed state
  output logic asleep_o,
  output int alarm_seen_o,
  output int ms_seen_o
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      asleep_o <= 1'b0;
    end else if (wake_i) begin
      asleep_o <= 1'b0;
    end else if (sleep_req_i) begin
      asleep_o <= 1'b1;
    end
  end
  // Separate tallies show the lines do not share pulses
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      alarm_seen_o <= 0;
      ms_seen_o <= 0;
    end else begin
      alarm_seen_o <= alarm_seen_o + int'(alarm_irq_i);
      ms_seen_o <= ms_seen_o + int'(ms_irq_i);
    end
  end
endmodule : rtc_power_model

// *** verification/tb.sv ***
// Self-checking bench for the seconds counter and fine wake timer.
// Assumes short dividers, so one second is MS_DIV*SEC_DIV cycles.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import rtc_pkg::*;
  localparam int MS_DIV = 4;
  localparam int SEC_DIV = 3;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic sec_enable_i = 1'b0;
  logic match_wr_i = 1'b0;
  logic ms_wr_i = 1'b0;
  logic sleep_req = 1'b0;
  rtc_sec_wr_t sec_wr_i = '0;
  logic [31:0] match_value_i = '0;
  logic [15:0] ms_value_i = '0;
  logic [31:0] sec_count_o, v;
  logic [15:0] ms_count_o;
  logic ms_running_o, alarm_irq_o, ms_irq_o, wake_o, asleep;
  int alarm_seen, ms_seen, k, n;
  int failures = 0;
  int checked = 0;
  logic [31:0] seed = 32'h6e17;
  always #25 clock_i = ~clock_i;
  rtc_timers #(.MS_DIV(MS_DIV), .SEC_DIV(SEC_DIV)) u_dut (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .sec_enable_i(sec_enable_i), .sec_wr_i(sec_wr_i), .match_wr_i(match_wr_i),
    .match_value_i(match_value_i), .ms_wr_i(ms_wr_i), .ms_value_i(ms_value_i),
    .sec_count_o(sec_count_o), .ms_count_o(ms_count_o), .ms_running_o(ms_running_o),
    .alarm_irq_o(alarm_irq_o), .ms_irq_o(ms_irq_o), .wake_o(wake_o));
  rtc_power_model u_pwr (.clock_i(clock_i), .rst_b_i(rst_b_i), .sleep_req_i(sleep_req),
    .alarm_irq_i(alarm_irq_o), .ms_irq_i(ms_irq_o), .wake_i(wake_o), .asleep_o(asleep),
    .alarm_seen_o(alarm_seen), .ms_seen_o(ms_seen));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // Cycles between two 1 Hz ticks
  function automatic int sec_cycles();
    return MS_DIV * SEC_DIV;
  endfunction : sec_cycles
  // First tick may fall anywhere in one 1 kHz period after the write
  function automatic logic ms_in_window(input int cnt, input int waited);
    return (waited > (cnt - 1) * MS_DIV) && (waited <= cnt * MS_DIV);
  endfunction : ms_in_window
  task automatic step(input int c);
    repeat (c) @(posedge clock_i);
    #2;
  endtask : step
  task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_val
  task automatic wait_hi(ref logic sig, input int lim);
    k = 0;
    do begin
      step(1);
      k++;
    end while (sig !== 1'b1 && k < lim);
  endtask : wait_hi
  task automatic put_ms(input logic [15:0] c);
    ms_value_i = c;
    ms_wr_i = 1'b1;
    step(1);
    ms_wr_i = 1'b0;
  endtask : put_ms
  task automatic put_sec(input logic [31:0] s, input logic [31:0] m);
    match_value_i = m;
    match_wr_i = 1'b1;
    sec_wr_i = '{clear: 1'b0, load: 1'b1, value: s};
    step(1);
    match_wr_i = 1'b0;
    sec_wr_i = '0;
  endtask : put_sec
  task automatic wrap_up();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #(50 * 6000);
    failures++;
    wrap_up();
  end
  initial begin
    step(10);
    rst_b_i = 1'b1;
    step(1);
    chk_val("reset sec", '0, sec_count_o);
    v = rnd();
    put_sec(v, v + 32'h2);
    chk_val("loaded sec", v, sec_count_o);
    sec_enable_i = 1'b1;
    wait_hi(alarm_irq_o, 3 * sec_cycles());
    chk_val("sec at alarm", v + 32'h2, sec_count_o);
    n = 0;
    while (sec_count_o === v + 32'h2 && n < 100) begin
      step(1);
      n++;
    end
    chk_val("second period", sec_cycles(), n);
    sec_enable_i = 1'b0;
    step(40);
    chk_val("disabled sec", v + 32'h3, sec_count_o);
    sec_wr_i = '{clear: 1'b1, load: 1'b1, value: rnd()};
    step(1);
    sec_wr_i = '0;
    chk_val("cleared sec", '0, sec_count_o);
    for (int i = 0; i < 4; i++) begin
      n = (i == 0) ? 1 : int'(rnd() % 32'h5) + 1;
      put_ms(16'(n));
      chk_val("ms loaded", n, ms_count_o);
      wait_hi(ms_irq_o, n * MS_DIV + 4);
      chk_val("ms window", 1, ms_in_window(n, k));
      chk_val("ms at expiry", '0, ms_count_o);
      step(1);
      chk_val("wake", 1, wake_o);
      chk_val("ms running", 0, ms_running_o);
    end
    put_ms(16'h0005);
    step(1);
    put_ms(16'h0000);
    wait_hi(ms_irq_o, 40);
    chk_val("zero write irq", 0, ms_irq_o);
    chk_val("zero write count", 0, ms_count_o);
    chk_val("zero write idle", 0, ms_running_o);
    put_sec(32'h7, 32'h8);
    sec_enable_i = 1'b1;
    put_ms(16'h0002);
    sleep_req = 1'b1;
    step(1);
    sleep_req = 1'b0;
    chk_val("asleep", 1, asleep);
    chk_val("ms running on", 1, ms_running_o);
    step(3 * sec_cycles());
    chk_val("woken", 0, asleep);
    chk_val("alarm count", 2, alarm_seen);
    chk_val("ms count", 5, ms_seen);
    wrap_up();
  end
endmodule : tb
